/* File: hw/eecl_defs.vh */
`ifndef EECL_DEFS_VH
`define EECL_DEFS_VH

// EEPROM word byte addresses walked by the loader, in order
`define EECL_W0C        8'h0c
`define EECL_W0E        8'h0e
`define EECL_W10        8'h10
`define EECL_W12        8'h12
`define EECL_W14        8'h14

// Load sequence indices and strobe vector width
`define EECL_IDX_0C     0
`define EECL_IDX_0E     1
`define EECL_IDX_10     2
`define EECL_IDX_12     3
`define EECL_IDX_14     4
`define EECL_NWORDS     5
`define EECL_LAST_IDX   3'h4
`define EECL_IDX_ONE    3'h1

// Port count and flat image width (six 32-bit images)
`define EECL_NPORTS     6
`define EECL_IMG_W      192
`define EECL_PORT_MAX   3'h5

// Field defaults before any load
`define EECL_DFLT_0C    16'h0000
`define EECL_DFLT_0E    16'h0000
`define EECL_DFLT_10    16'h0000
`define EECL_DFLT_12    16'h0000
`define EECL_DFLT_14    4'h0

// Bits that port 0 never takes from the word
`define EECL_P0_KEEP_0C 16'h0200
`define EECL_P0_KEEP_12 16'h8000
`define EECL_NO_KEEP    16'h0000

// Source bit positions inside an EEPROM word
`define EECL_S_MPS      1:0
`define EECL_S_ASPM     3:2
`define EECL_S_RBER     4
`define EECL_S_MSIDIS   5
`define EECL_S_CPPDIS   6
`define EECL_S_PMDIS    7
`define EECL_S_ORD5     8
`define EECL_S_LBN      9
`define EECL_S_ORDFRZ   10
`define EECL_S_SOFLAT   11
`define EECL_S_SDE      12
`define EECL_S_PMDS     13
`define EECL_S_LTR      14
`define EECL_S_BND4K    15
`define EECL_S_F0       4:0
`define EECL_S_F1       9:5
`define EECL_S_F2       14:10
`define EECL_S_B15      15
`define EECL_S_TXLAT    3:0

// Destination bit positions inside the per-port images
`define EECL_D_MPS      1:0
`define EECL_D_RBER     15
`define EECL_D_ASPM     11:10
`define EECL_D_LBN      21
`define EECL_D_SDE      19
`define EECL_D_MSIDIS   14
`define EECL_D_PMDIS    13
`define EECL_D_CPPDIS   15
`define EECL_D_ORD5     5
`define EECL_D_ORDFRZ   6
`define EECL_D_SOFLAT   0
`define EECL_D_PMDS     1
`define EECL_D_BND4K    3
`define EECL_D_RATE2    31
`define EECL_D_LTR      12
`define EECL_D_OBFF     18
`define EECL_D_HI0      20:16
`define EECL_D_HI1      25:21
`define EECL_D_HI2      30:26
`define EECL_D_INTA     8
`define EECL_D_TXLAT    3:0

// AHB register byte offsets
`define EECL_A_CTRL     8'h00
`define EECL_A_STATUS   8'h04
`define EECL_A_PSEL     8'h08
`define EECL_A_I3C      8'h40
`define EECL_A_I70      8'h44
`define EECL_A_I74      8'h48
`define EECL_A_I78      8'h4c
`define EECL_A_I7C      8'h50
`define EECL_A_I8C      8'h54
`define EECL_A_I94      8'h58
`define EECL_A_IC4      8'h5c
`define EECL_A_ICC      8'h60
`define EECL_A_IE4      8'h64

// Register fields
`define EECL_CTRL_RELOAD 0
`define EECL_ST_BUSY    0
`define EECL_ST_READY   1
`define EECL_ST_IDX     6:4
`define EECL_PSEL_F     2:0
`define EECL_ZERO32     32'h0000_0000

`endif

/* File: hw/eecl_word_fetch.v */
`timescale 1ns/1ps
`include "eecl_defs.vh"

module eecl_word_fetch (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // Command from the sequencer
  input  wire        go,
  input  wire [7:0]  addr,
  output reg         done_ff,
  output reg  [15:0] data_ff,
  // EEPROM word reader
  output reg         ee_rd_req_ff,
  output reg  [7:0]  ee_rd_addr_ff,
  input  wire        ee_rd_ack,
  input  wire [15:0] ee_rd_data
);

  // Request holds until the reader acks; the word is latched so it is stable for one load pulse
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ee_rd_req_ff  <= 1'b0;
      ee_rd_addr_ff <= 8'h00;
      done_ff       <= 1'b0;
      data_ff       <= 16'h0000;
    end else begin
      done_ff <= 1'b0;
      if (go && !ee_rd_req_ff) begin
        ee_rd_req_ff  <= 1'b1;
        ee_rd_addr_ff <= addr;
      end else if (ee_rd_req_ff && ee_rd_ack) begin
        ee_rd_req_ff <= 1'b0;
        data_ff      <= ee_rd_data;
        done_ff      <= 1'b1;
      end
    end
  end

endmodule

/* File: hw/eecl_ahb_front.v */
`timescale 1ns/1ps
`include "eecl_defs.vh"

module eecl_ahb_front (
  // Clock and reset
  input  wire       hclk,
  input  wire       hresetn,
  // AHB-Lite address phase
  input  wire       hsel,
  input  wire [1:0] htrans,
  input  wire       hwrite,
  input  wire [7:0] haddr_lo,
  input  wire       hready,
  // Decoded accesses
  output wire       ap_rd,
  output reg        dp_wr_ff,
  output reg  [7:0] dp_addr_ff,
  // Slave answer
  output reg        hreadyout_ff,
  output reg        hresp_ff
);

  wire ap_valid;

  // NONSEQ or SEQ with the slave selected and the bus ready
  assign ap_valid = hsel && htrans[1] && hready;
  assign ap_rd    = ap_valid && !hwrite;

  // Writes complete in the data phase; slave never stalls nor errors
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_ff     <= 1'b0;
      dp_addr_ff   <= 8'h00;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end else begin
      dp_wr_ff     <= ap_valid && hwrite;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
      if (ap_valid) begin
        dp_addr_ff <= haddr_lo;
      end
    end
  end

endmodule

/* File: hw/eecl_loader.v */
// Implementation choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "eecl_defs.vh"


module eecl_loader (
  // Clock and reset
  input  wire                   hclk,
  input  wire                   hresetn,
  // AHB-Lite slave
  input  wire                   hsel,
  input  wire [31:0]            haddr,
  input  wire [1:0]             htrans,
  input  wire                   hwrite,
  input  wire [2:0]             hsize,
  input  wire [31:0]            hwdata,
  input  wire                   hready,
  output reg  [31:0]            hrdata,
  output wire                   hreadyout,
  output wire                   hresp,
  // EEPROM word reader
  output wire                   ee_rd_req,
  output wire [7:0]             ee_rd_addr,
  input  wire                   ee_rd_ack,
  input  wire [15:0]            ee_rd_data,
  // Configuration access gate
  output wire                   cfg_ready,
  // Per-port images, port p in bits [p*32 +: 32]
  output wire [`EECL_IMG_W-1:0] cfg_img_3c,
  output wire [`EECL_IMG_W-1:0] cfg_img_70,
  output wire [`EECL_IMG_W-1:0] cfg_img_74,
  output wire [`EECL_IMG_W-1:0] cfg_img_78,
  output wire [`EECL_IMG_W-1:0] cfg_img_7c,
  output wire [`EECL_IMG_W-1:0] cfg_img_8c,
  output wire [`EECL_IMG_W-1:0] cfg_img_94,
  output wire [`EECL_IMG_W-1:0] cfg_img_c4,
  output wire [`EECL_IMG_W-1:0] cfg_img_cc,
  output wire [`EECL_IMG_W-1:0] cfg_img_e4
);

  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_REQ  = 4'b0010;
  localparam [3:0] ST_WAIT = 4'b0100;
  localparam [3:0] ST_DONE = 4'b1000;

  reg  [3:0]              state_ff;
  reg  [3:0]              nxt_state;
  reg  [2:0]              idx_ff;
  reg  [2:0]              nxt_idx;
  reg                     boot_pend_ff;
  reg                     ready_ff;
  reg                     nxt_ready;
  reg                     reload_req_ff;
  reg  [2:0]              psel_ff;
  reg  [7:0]              word_addr;
  reg  [`EECL_NWORDS-1:0] ld_stb;
  reg  [31:0]             rd_val;
  wire                    ap_rd;
  wire                    dp_wr;
  wire [7:0]              dp_addr;
  wire                    fetch_go;
  wire                    fetch_done;
  wire [15:0]             fetch_data;
  wire                    start;

  assign cfg_ready = ready_ff;

  // Bus front end: address capture and the fixed OKAY, zero-wait answer
  eecl_ahb_front u_front (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .hsel         (hsel),
    .htrans       (htrans),
    .hwrite       (hwrite),
    .haddr_lo     (haddr[7:0]),
    .hready       (hready),
    .ap_rd        (ap_rd),
    .dp_wr_ff     (dp_wr),
    .dp_addr_ff   (dp_addr),
    .hreadyout_ff (hreadyout),
    .hresp_ff     (hresp)
  );

  // One EEPROM word per request; serial protocol lives in the reader
  eecl_word_fetch u_fetch (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .go            (fetch_go),
    .addr          (word_addr),
    .done_ff       (fetch_done),
    .data_ff       (fetch_data),
    .ee_rd_req_ff  (ee_rd_req),
    .ee_rd_addr_ff (ee_rd_addr),
    .ee_rd_ack     (ee_rd_ack),
    .ee_rd_data    (ee_rd_data)
  );

  // Word address for the current step of the walk
  always @* begin
    case (idx_ff)
      3'h0:    word_addr = `EECL_W0C;
      3'h1:    word_addr = `EECL_W0E;
      3'h2:    word_addr = `EECL_W10;
      3'h3:    word_addr = `EECL_W12;
      default: word_addr = `EECL_W14;
    endcase
  end

  // Boot load runs once after reset; software reload only from idle
  assign start    = (boot_pend_ff || reload_req_ff) && (state_ff == ST_IDLE);
  assign fetch_go = (state_ff == ST_REQ);

  // Sequencer walks words 0Ch..14h and raises ready only when all are in
  always @* begin
    nxt_state = state_ff;
    nxt_idx   = idx_ff;
    nxt_ready = ready_ff;
    ld_stb    = {`EECL_NWORDS{1'b0}};
    case (state_ff)
      ST_IDLE: begin
        if (start) begin
          nxt_state = ST_REQ;
          nxt_idx   = 3'h0;
          nxt_ready = 1'b0;
        end
      end
      ST_REQ: begin
        nxt_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (fetch_done) begin
          ld_stb[idx_ff] = 1'b1;
          if (idx_ff == `EECL_LAST_IDX) begin
            nxt_state = ST_DONE;
          end else begin
            nxt_idx   = idx_ff + `EECL_IDX_ONE;
            nxt_state = ST_REQ;
          end
        end
      end
      ST_DONE: begin
        nxt_ready = 1'b1;
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  // Sequencer state
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff     <= ST_IDLE;
      idx_ff       <= 3'h0;
      ready_ff     <= 1'b0;
      boot_pend_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      idx_ff   <= nxt_idx;
      ready_ff <= nxt_ready;
      if (start) begin
        boot_pend_ff <= 1'b0;
      end
    end
  end

  // Software registers; a reload asked for while busy waits for idle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reload_req_ff <= 1'b0;
      psel_ff       <= 3'h0;
    end else begin
      if (dp_wr && dp_addr == `EECL_A_CTRL && hwdata[`EECL_CTRL_RELOAD]) begin
        reload_req_ff <= 1'b1;
      end else if (start) begin
        reload_req_ff <= 1'b0;
      end
      // Out-of-range port numbers are dropped so the readback never leaves the images
      if (dp_wr && dp_addr == `EECL_A_PSEL && hwdata[`EECL_PSEL_F] <= `EECL_PORT_MAX) begin
        psel_ff <= hwdata[`EECL_PSEL_F];
      end
    end
  end

  // Per-port field storage and image assembly
  genvar p;
  generate
    for (p = 0; p < `EECL_NPORTS; p = p + 1) begin : g_port
      localparam [15:0] KEEP_0C = (p == 0) ? `EECL_P0_KEEP_0C : `EECL_NO_KEEP;
      localparam [15:0] KEEP_12 = (p == 0) ? `EECL_P0_KEEP_12 : `EECL_NO_KEEP;
      reg [15:0] w0c_ff;
      reg [15:0] w0e_ff;
      reg [15:0] w10_ff;
      reg [15:0] w12_ff;
      reg [3:0]  w14_ff;
      reg [31:0] i3c;
      reg [31:0] i70;
      reg [31:0] i74;
      reg [31:0] i78;
      reg [31:0] i7c;
      reg [31:0] i8c;
      reg [31:0] i94;
      reg [31:0] ic4;
      reg [31:0] icc;
      reg [31:0] ie4;

      // Same word goes to every port; port 0 keeps its defaults where excluded
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          w0c_ff <= `EECL_DFLT_0C;
          w0e_ff <= `EECL_DFLT_0E;
          w10_ff <= `EECL_DFLT_10;
          w12_ff <= `EECL_DFLT_12;
          w14_ff <= `EECL_DFLT_14;
        end else begin
          if (ld_stb[`EECL_IDX_0C]) begin
            w0c_ff <= (fetch_data & ~KEEP_0C) | (w0c_ff & KEEP_0C);
          end
          if (ld_stb[`EECL_IDX_0E]) begin
            w0e_ff <= fetch_data;
          end
          if (ld_stb[`EECL_IDX_10]) begin
            w10_ff <= fetch_data;
          end
          if (ld_stb[`EECL_IDX_12]) begin
            w12_ff <= (fetch_data & ~KEEP_12) | (w12_ff & KEEP_12);
          end
          if (ld_stb[`EECL_IDX_14]) begin
            w14_ff <= fetch_data[`EECL_S_TXLAT];
          end
        end
      end

      // Scatter stored word bits into their register fields; other bits read zero
      always @* begin
        i3c = `EECL_ZERO32;
        i70 = `EECL_ZERO32;
        i74 = `EECL_ZERO32;
        i78 = `EECL_ZERO32;
        i7c = `EECL_ZERO32;
        i8c = `EECL_ZERO32;
        i94 = `EECL_ZERO32;
        ic4 = `EECL_ZERO32;
        icc = `EECL_ZERO32;
        ie4 = `EECL_ZERO32;
        ic4[`EECL_D_MPS]    = w0c_ff[`EECL_S_MPS];
        icc[`EECL_D_ASPM]   = w0c_ff[`EECL_S_ASPM];
        ic4[`EECL_D_RBER]   = w0c_ff[`EECL_S_RBER];
        i70[`EECL_D_MSIDIS] = w0c_ff[`EECL_S_MSIDIS];
        i74[`EECL_D_CPPDIS] = w0c_ff[`EECL_S_CPPDIS];
        i70[`EECL_D_PMDIS]  = w0c_ff[`EECL_S_PMDIS];
        i8c[`EECL_D_ORD5]   = w0c_ff[`EECL_S_ORD5];
        icc[`EECL_D_LBN]    = w0c_ff[`EECL_S_LBN];
        i8c[`EECL_D_ORDFRZ] = w0c_ff[`EECL_S_ORDFRZ];
        i8c[`EECL_D_SOFLAT] = w0c_ff[`EECL_S_SOFLAT];
        icc[`EECL_D_SDE]    = w0c_ff[`EECL_S_SDE];
        i8c[`EECL_D_PMDS]   = w0c_ff[`EECL_S_PMDS];
        ie4[`EECL_D_LTR]    = w0c_ff[`EECL_S_LTR];
        i8c[`EECL_D_BND4K]  = w0c_ff[`EECL_S_BND4K];
        i94[`EECL_S_F0]     = w0e_ff[`EECL_S_F0];
        i94[`EECL_S_F1]     = w0e_ff[`EECL_S_F1];
        i94[`EECL_S_F2]     = w0e_ff[`EECL_S_F2];
        ie4[`EECL_D_OBFF]   = w0e_ff[`EECL_S_B15];
        i74[`EECL_D_HI0]    = w10_ff[`EECL_S_F0];
        i74[`EECL_D_HI1]    = w10_ff[`EECL_S_F1];
        i74[`EECL_D_HI2]    = w10_ff[`EECL_S_F2];
        i8c[`EECL_D_RATE2]  = w10_ff[`EECL_S_B15];
        i78[`EECL_D_HI0]    = w12_ff[`EECL_S_F0];
        i78[`EECL_D_HI1]    = w12_ff[`EECL_S_F1];
        i78[`EECL_D_HI2]    = w12_ff[`EECL_S_F2];
        i3c[`EECL_D_INTA]   = w12_ff[`EECL_S_B15];
        i7c[`EECL_D_TXLAT]  = w14_ff;
      end

      // Images are pure wiring of the field flops
      assign cfg_img_3c[p*32 +: 32] = i3c;
      assign cfg_img_70[p*32 +: 32] = i70;
      assign cfg_img_74[p*32 +: 32] = i74;
      assign cfg_img_78[p*32 +: 32] = i78;
      assign cfg_img_7c[p*32 +: 32] = i7c;
      assign cfg_img_8c[p*32 +: 32] = i8c;
      assign cfg_img_94[p*32 +: 32] = i94;
      assign cfg_img_c4[p*32 +: 32] = ic4;
      assign cfg_img_cc[p*32 +: 32] = icc;
      assign cfg_img_e4[p*32 +: 32] = ie4;
    end
  endgenerate

  // Readback value chosen in the address phase; unmapped offsets read zero
  always @* begin
    rd_val = `EECL_ZERO32;
    case (haddr[7:0])
      `EECL_A_STATUS: begin
        rd_val[`EECL_ST_BUSY]  = ~state_ff[0];
        rd_val[`EECL_ST_READY] = ready_ff;
        rd_val[`EECL_ST_IDX]   = idx_ff;
      end
      `EECL_A_PSEL: rd_val[`EECL_PSEL_F] = psel_ff;
      `EECL_A_I3C:  rd_val = cfg_img_3c[psel_ff*32 +: 32];
      `EECL_A_I70:  rd_val = cfg_img_70[psel_ff*32 +: 32];
      `EECL_A_I74:  rd_val = cfg_img_74[psel_ff*32 +: 32];
      `EECL_A_I78:  rd_val = cfg_img_78[psel_ff*32 +: 32];
      `EECL_A_I7C:  rd_val = cfg_img_7c[psel_ff*32 +: 32];
      `EECL_A_I8C:  rd_val = cfg_img_8c[psel_ff*32 +: 32];
      `EECL_A_I94:  rd_val = cfg_img_94[psel_ff*32 +: 32];
      `EECL_A_IC4:  rd_val = cfg_img_c4[psel_ff*32 +: 32];
      `EECL_A_ICC:  rd_val = cfg_img_cc[psel_ff*32 +: 32];
      `EECL_A_IE4:  rd_val = cfg_img_e4[psel_ff*32 +: 32];
      default:      rd_val = `EECL_ZERO32;
    endcase
  end

  // Read data registered at the address phase so it stands through the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `EECL_ZERO32;
    end else if (ap_rd) begin
      hrdata <= rd_val;
    end
  end

endmodule

/* File: sim/eecl_loader_properties.sv */
`timescale 1ns/1ps
`include "eecl_defs.vh"

module eecl_loader_properties (
  // Clock and reset
  input wire                   hclk,
  input wire                   hresetn,
  // Bus answer
  input wire                   hreadyout,
  input wire                   hresp,
  // EEPROM reader
  input wire                   ee_rd_req,
  input wire [7:0]             ee_rd_addr,
  input wire                   ee_rd_ack,
  input wire [15:0]            ee_rd_data,
  // Loaded images
  input wire                   cfg_ready,
  input wire [`EECL_IMG_W-1:0] cfg_img_3c,
  input wire [`EECL_IMG_W-1:0] cfg_img_74,
  input wire [`EECL_IMG_W-1:0] cfg_img_78,
  input wire [`EECL_IMG_W-1:0] cfg_img_7c,
  input wire [`EECL_IMG_W-1:0] cfg_img_8c,
  input wire [`EECL_IMG_W-1:0] cfg_img_94,
  input wire [`EECL_IMG_W-1:0] cfg_img_cc
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // A word accepted from the reader at this edge
  sequence s_ack(a);
    ee_rd_req && ee_rd_ack && ee_rd_addr == a;
  endsequence
  // Two quiet cycles between word requests
  sequence s_gap;
    !ee_rd_req [*2];
  endsequence

  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not OKAY with no wait");
  chk_req_holds: assert property (ee_rd_req && !ee_rd_ack |=> ee_rd_req && $stable(ee_rd_addr))
    else $error("word request dropped or moved before ack");
  chk_next_word: assert property (ee_rd_req && ee_rd_ack && ee_rd_addr != 8'h14 |=>
    s_gap ##1 (ee_rd_req && ee_rd_addr == $past(ee_rd_addr, 3) + 8'h02))
    else $error("next word not requested in order");
  chk_word0c_fields: assert property (s_ack(8'h0c) |-> ##2
    (cfg_img_8c[165] == $past(ee_rd_data[8], 2) && cfg_img_cc[181] == $past(ee_rd_data[9], 2)
     && cfg_img_cc[11:10] == $past(ee_rd_data[3:2], 2)))
    else $error("word 0c fields not loaded");
  chk_word10_fields: assert property (s_ack(8'h10) |-> ##2
    (cfg_img_74[30:16] == $past(ee_rd_data[14:0], 2) && cfg_img_8c[191] == $past(ee_rd_data[15], 2)))
    else $error("word 10 fields not loaded");
  chk_ready_after: assert property (s_ack(8'h14) |-> ##[2:6] cfg_ready)
    else $error("ready not raised after last word");
  chk_busy_gate: assert property (ee_rd_req |-> !cfg_ready)
    else $error("ready high while loading");
  chk_port0_masked: assert property (cfg_img_3c[8] == 1'b0 && cfg_img_cc[21] == 1'b0)
    else $error("port 0 took a ports 1-5 field");
  chk_ports_same: assert property (cfg_ready |->
    cfg_img_94[14:0] == cfg_img_94[174:160] && cfg_img_78[30:16] == cfg_img_78[62:48])
    else $error("ports differ in a shared field");
  chk_unloaded_zero: assert property (cfg_img_7c[31:4] == 28'h0 && cfg_img_7c[191:164] == 28'h0)
    else $error("unloaded latency bits not default");
endmodule

bind eecl_loader eecl_loader_properties chk_i (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .ee_rd_req(ee_rd_req), .ee_rd_addr(ee_rd_addr), .ee_rd_ack(ee_rd_ack),
  .ee_rd_data(ee_rd_data), .cfg_ready(cfg_ready), .cfg_img_3c(cfg_img_3c),
  .cfg_img_74(cfg_img_74), .cfg_img_78(cfg_img_78), .cfg_img_7c(cfg_img_7c),
  .cfg_img_8c(cfg_img_8c), .cfg_img_94(cfg_img_94), .cfg_img_cc(cfg_img_cc)
);

/* File: sim/eecl_eeprom_model.sv */
`timescale 1ns/1ps

module eecl_eeprom_model (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // Word contents, word 0c in the low bits, and answer delay
  input  wire [79:0] words,
  input  wire [3:0]  lag,
  // Word reader
  input  wire        ee_rd_req,
  input  wire [7:0]  ee_rd_addr,
  output reg         ee_rd_ack,
  output reg  [15:0] ee_rd_data
);
  reg  [3:0] wait_ff;
  wire [7:0] off = ee_rd_addr - 8'h0c;

  // One-cycle ack after lag cycles; data toggles outside the ack so stale reads show
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ee_rd_ack  <= 1'b0;
      ee_rd_data <= 16'h5a5a;
      wait_ff    <= 4'h0;
    end else if (ee_rd_req && !ee_rd_ack && wait_ff == lag) begin
      ee_rd_ack  <= 1'b1;
      ee_rd_data <= words[off[3:1]*16 +: 16];
      wait_ff    <= 4'h0;
    end else begin
      ee_rd_ack  <= 1'b0;
      ee_rd_data <= ~ee_rd_data;
      wait_ff    <= (ee_rd_req && !ee_rd_ack) ? wait_ff + 4'h1 : 4'h0;
    end
  end
endmodule

/* File: sim/eeprom_config_field_loader_bench.sv */
`timescale 1ns/1ps
`include "eecl_defs.vh"

module eeprom_config_field_loader_bench;
  reg          hclk, hresetn, hsel, hwrite;
  reg  [1:0]   htrans;
  reg  [2:0]   hsize;
  reg  [31:0]  haddr, hwdata, rd;
  reg  [15:0]  w [0:4];
  reg  [3:0]   lag;
  wire [31:0]  hrdata;
  wire         hreadyout, hresp, ee_rd_req, ee_rd_ack, cfg_ready;
  wire [7:0]   ee_rd_addr;
  wire [15:0]  ee_rd_data;
  wire [191:0] img [0:9];
  integer      err_total, comparisons, cyc, k, p;

  eecl_loader dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ee_rd_req(ee_rd_req),
    .ee_rd_addr(ee_rd_addr), .ee_rd_ack(ee_rd_ack), .ee_rd_data(ee_rd_data),
    .cfg_ready(cfg_ready), .cfg_img_3c(img[0]), .cfg_img_70(img[1]), .cfg_img_74(img[2]),
    .cfg_img_78(img[3]), .cfg_img_7c(img[4]), .cfg_img_8c(img[5]), .cfg_img_94(img[6]),
    .cfg_img_c4(img[7]), .cfg_img_cc(img[8]), .cfg_img_e4(img[9]));

  eecl_eeprom_model rom (.hclk(hclk), .hresetn(hresetn), .words({w[4], w[3], w[2], w[1], w[0]}),
    .lag(lag), .ee_rd_req(ee_rd_req), .ee_rd_addr(ee_rd_addr), .ee_rd_ack(ee_rd_ack),
    .ee_rd_data(ee_rd_data));

  // Clock and a hang guard well above three loads, one cut-off load and bus traffic
  always #25 hclk = ~hclk;
  always @(posedge hclk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      err_total = err_total + 1;
      tally_and_finish;
    end
  end

  // Compare and count
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
    end
  endtask

  // Expected image k of port p from the current words
  function [31:0] exp_img(input integer k, input integer p);
    reg [15:0] a;
    begin
      a = w[0];
      exp_img = 32'h0000_0000;
      case (k)
        0: exp_img[8] = (p != 0) & w[3][15];
        1: begin exp_img[14] = a[5]; exp_img[13] = a[7]; end
        2: exp_img = {1'b0, w[2][14:0], a[6], 15'h0000};
        3: exp_img = {1'b0, w[3][14:0], 16'h0000};
        4: exp_img[3:0] = w[4][3:0];
        5: exp_img = {w[2][15], 24'h00_0000, a[10], a[8], 1'b0, a[15], 1'b0, a[13], a[11]};
        6: exp_img = {17'h0_0000, w[1][14:0]};
        7: begin exp_img[15] = a[4]; exp_img[1:0] = a[1:0]; end
        8: begin exp_img[21] = (p != 0) & a[9]; exp_img[19] = a[12]; exp_img[11:10] = a[3:2]; end
        default: begin exp_img[18] = w[1][15]; exp_img[12] = a[14]; end
      endcase
    end
  endfunction

  // Every image of every port against the words
  task check_all;
    for (k = 0; k < 10; k = k + 1)
      for (p = 0; p < 6; p = p + 1)
        chk(img[k][p*32 +: 32], exp_img(k, p));
  endtask

  // One single AHB transfer; wait states are waited out on hreadyout, the guard ends a stall
  task ahb(input wr, input [7:0] a, input [31:0] wd);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h00_0000, a};
      hwrite <= wr;
      hsize <= 3'b010;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
    end
  endtask

  // Wait for the load to finish, bounded
  task wait_ready;
    integer n;
    begin
      n = 0;
      while (cfg_ready !== 1'b1 && n < 400) begin
        @(posedge hclk);
        n = n + 1;
      end
      chk({31'h0, cfg_ready}, 32'h1);
    end
  endtask

  task tally_and_finish;
    begin
      if (err_total == 0 && comparisons > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  // Boot load, register access, slow reload, reload latched while busy, reset mid-load
  initial begin
    hclk = 0; hresetn = 0; hsel = 0; htrans = 0; hwrite = 0; hsize = 0;
    haddr = 0; hwdata = 0; lag = 0; err_total = 0; comparisons = 0; cyc = 0;
    w[0] = 16'ha5c3; w[1] = 16'h3c5a; w[2] = 16'h96e1; w[3] = 16'h5b2d; w[4] = 16'hfff9;
    repeat (3) @(posedge hclk);
    chk({28'h0, hreadyout, hresp, ee_rd_req, cfg_ready}, 32'h8);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk({31'h0, cfg_ready}, 32'h0);
    wait_ready;
    check_all;
    ahb(1'b0, `EECL_A_STATUS, 32'h0);
    chk(rd & 32'h73, 32'h42);
    ahb(1'b1, `EECL_A_PSEL, 32'h3);
    ahb(1'b1, `EECL_A_PSEL, 32'h6);
    ahb(1'b0, `EECL_A_PSEL, 32'h0);
    chk(rd & 32'h7, 32'h3);
    ahb(1'b1, `EECL_A_I8C, 32'hffff_ffff);
    for (k = 0; k < 10; k = k + 1) begin
      ahb(1'b0, 8'h40 + {k[5:0], 2'b00}, 32'h0);
      chk(rd, exp_img(k, 3));
    end
    ahb(1'b0, 8'h30, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, `EECL_A_CTRL, 32'h0);
    chk(rd, 32'h0);
    for (k = 0; k < 5; k = k + 1) w[k] <= ~w[k];
    lag <= 4'h3;
    ahb(1'b1, `EECL_A_CTRL, 32'h1);
    repeat (2) @(posedge hclk);
    chk({31'h0, cfg_ready}, 32'h0);
    ahb(1'b0, `EECL_A_STATUS, 32'h0);
    chk(rd & 32'h3, 32'h1);
    // A reload asked for while busy must run once the current load ends
    ahb(1'b1, `EECL_A_CTRL, 32'h1);
    wait_ready;
    check_all;
    ahb(1'b0, `EECL_A_STATUS, 32'h0);
    chk(rd & 32'h3, 32'h1);
    ahb(1'b1, `EECL_A_CTRL, 32'h1);
    repeat (6) @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    for (k = 0; k < 10; k = k + 1) chk(img[k][31:0], 32'h0);
    hresetn <= 1'b1;
    wait_ready;
    check_all;
    tally_and_finish;
  end
endmodule
